// ### verilog/ccu_pkg.sv
// Constants, register map and mode codes of the capture/compare block.
package ccu_pkg;
    localparam int UNIT_N = 2;
    localparam int UNIT_CH = 16;
    localparam int CH_N = 32;
    localparam int TMR_N = 4;
    localparam int TW = 16;
    localparam int AW = 10;
    localparam logic [TW-1:0] TMR_MAX = 16'hFFFF;

    // Byte addresses; each unit occupies one window of UNIT_STRIDE bytes.
    localparam int UNIT_STRIDE = 'h100;
    localparam int OFF_TMR = 'h00;
    localparam int OFF_REL = 'h08;
    localparam int OFF_TCTL = 'h10;
    localparam int OFF_VAL = 'h40;
    localparam int OFF_CTL = 'h80;
    localparam logic [AW-1:0] ADDR_STAT = 10'h200;
    localparam logic [AW-1:0] ADDR_MASK = 10'h204;

    // Channel control word layout.
    localparam int CTL_W = 5;
    localparam int CTL_TSEL = 3;
    localparam int CTL_DBL = 4;
    localparam logic [CTL_W-1:0] CTL_RST = 5'h00;

    // Timer control: one byte per timer, timer 0 in the low byte.
    localparam int TF_STRIDE = 8;
    localparam int TF_SRC = 3;
    localparam int TF_RUN = 5;
    localparam logic [TW-1:0] TCTL_RST = 16'h0000;

    // Prescaler: code 0 divides by 8, each code doubles it.
    localparam int PRE_W = 10;
    localparam logic [PRE_W-1:0] PRE_MIN = 10'h008;

    typedef enum logic [2:0] {
        MODE_OFF = 3'b000,
        MODE_CAP_RISE = 3'b001,
        MODE_CAP_FALL = 3'b010,
        MODE_CAP_BOTH = 3'b011,
        MODE_CMP0 = 3'b100,
        MODE_CMP1 = 3'b101,
        MODE_CMP2 = 3'b110,
        MODE_CMP3 = 3'b111
    } ccu_mode_t;

    typedef enum logic [1:0] {
        SRC_PRE = 2'b00,
        SRC_GPT = 2'b01,
        SRC_EXT = 2'b10,
        SRC_STOP = 2'b11
    } ccu_src_t;
endpackage

// ### verilog/ccu_top.sv
// Two capture/compare units with their time bases and an AHB-Lite slave.
// Function
// - There are two independent units of sixteen channels, 32 in all.
// - Each unit has two 16-bit timers, each with its own reload register.
// - A timer counts prescaled clock ticks or the external overflow pulse.
// - The first timer of each unit may also count an external input pin.
// - Each channel picks either unit timer and capture or compare use.
// - Each channel owns one pin: capture input or compare output.
// - A capture copies the chosen timer into the channel and flags it.
// - The capture edge is rising, falling or both, per channel.
// - Compare channels check their timer for equality on every count.
// - Compare mode 0 flags every match and leaves the pin alone.
// - Compare mode 1 inverts the pin on every match.
// - Compare mode 2 flags at most one match per timer period.
// - Compare mode 3 sets the pin on its one match, clears on overflow.
// - Double mode inverts one shared pin on a match of either register.
// - A 3-bit select per timer divides the clock by 8 up to 1024.
// - A timer counts from its reload value up to overflow.
`timescale 1ns/1ns
module ccu_top (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic external_gp_timer_overflow_source,
    input wire logic [ccu_pkg::UNIT_N-1:0] ext_count,
    input wire logic [ccu_pkg::CH_N-1:0] cc_pin_in,
    output logic [ccu_pkg::CH_N-1:0] cc_pin_out,
    output logic [ccu_pkg::CH_N-1:0] cc_pin_oe,
    output logic irq
);
    import ccu_pkg::*;

    logic acc_ok;
    logic wr_pend;
    logic rd_pend;
    logic [AW-1:0] wr_addr;
    logic [AW-1:0] rd_addr;
    logic [31:0] rd_data;
    logic [PRE_W-1:0] pre_cnt;
    logic [UNIT_N-1:0] ext_prev;
    logic [TW-1:0] tmr [TMR_N];
    logic [TW-1:0] rel [TMR_N];
    logic [TW-1:0] tctl [UNIT_N];
    logic [TMR_N-1:0] ovf;
    logic [TMR_N-1:0] chg;
    logic [TW-1:0] val [CH_N];
    logic [CTL_W-1:0] ctl [CH_N];
    logic [CH_N-1:0] hit;
    logic [CH_N-1:0] ev;
    logic [CH_N-1:0] pin_prev;
    logic [CH_N-1:0] stat;
    logic [CH_N-1:0] mask;

    // Tick of a prescaler code: all low bits of the divider set.
    function automatic logic pre_tick(input logic [2:0] code,
                                      input logic [PRE_W-1:0] cnt);
        logic [PRE_W-1:0] lo;
        lo = (PRE_MIN << code) - PRE_MIN[PRE_W-1:0] + PRE_MIN - 10'h001;
        return (cnt & lo) == lo;
    endfunction

    // Byte address of a register of unit u at offset off.
    function automatic logic [AW-1:0] reg_addr(input int u, input int off);
        return AW'(u * UNIT_STRIDE + off);
    endfunction

    assign acc_ok = hsel && htrans[1] && hready;

    // Address phase capture; reads get one wait state so that a write
    // in the preceding data phase is already visible to them.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            wr_addr <= '0;
            rd_addr <= '0;
        end else begin
            wr_pend <= acc_ok && hwrite;
            rd_pend <= acc_ok && !hwrite;
            if (acc_ok) begin
                wr_addr <= haddr[AW-1:0];
                rd_addr <= haddr[AW-1:0];
            end
        end
    end

    // Ready, response and read data all come from flops.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= '0;
        end else begin
            hreadyout <= !(acc_ok && !hwrite);
            hresp <= 1'b0;
            if (rd_pend) begin
                hrdata <= rd_data;
            end
        end
    end

    // Read multiplexer; unmapped addresses read as zero.
    always_comb begin
        rd_data = '0;
        for (int u = 0; u < UNIT_N; u++) begin
            for (int j = 0; j < 2; j++) begin
                if (rd_addr == reg_addr(u, OFF_TMR + 4 * j)) begin
                    rd_data = {16'h0000, tmr[u * 2 + j]};
                end
                if (rd_addr == reg_addr(u, OFF_REL + 4 * j)) begin
                    rd_data = {16'h0000, rel[u * 2 + j]};
                end
            end
            if (rd_addr == reg_addr(u, OFF_TCTL)) begin
                rd_data = {16'h0000, tctl[u]};
            end
        end
        for (int c = 0; c < CH_N; c++) begin
            if (rd_addr
                == reg_addr(c / UNIT_CH, OFF_VAL + 4 * (c % UNIT_CH))) begin
                rd_data = {16'h0000, val[c]};
            end
            if (rd_addr
                == reg_addr(c / UNIT_CH, OFF_CTL + 4 * (c % UNIT_CH))) begin
                rd_data = {27'h0000000, ctl[c]};
            end
        end
        if (rd_addr == ADDR_STAT) begin
            rd_data = stat;
        end
        if (rd_addr == ADDR_MASK) begin
            rd_data = mask;
        end
    end

    // Free-running divider shared by all timers, plus count pin history.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_cnt <= '0;
            ext_prev <= '0;
        end else begin
            pre_cnt <= pre_cnt + 10'h001;
            ext_prev <= ext_count;
        end
    end

    // Timer control registers, one per unit.
    for (genvar u = 0; u < UNIT_N; u++) begin : g_unit
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                tctl[u] <= TCTL_RST;
            end else if (wr_pend && wr_addr == reg_addr(u, OFF_TCTL)) begin
                tctl[u] <= hwdata[TW-1:0];
            end
        end
    end

    // Four time bases, two per unit.
    for (genvar t = 0; t < TMR_N; t++) begin : g_tmr
        localparam int U = t / 2;
        localparam int J = t % 2;
        logic [2:0] isel;
        ccu_src_t src;
        logic run;
        logic tick;
        logic wr_tmr;

        assign isel = tctl[U][J * TF_STRIDE +: 3];
        assign src = ccu_src_t'(tctl[U][J * TF_STRIDE + TF_SRC +: 2]);
        assign run = tctl[U][J * TF_STRIDE + TF_RUN];
        assign wr_tmr = wr_pend && wr_addr == reg_addr(U, OFF_TMR + 4 * J);

        // Count source; only the first timer of a unit has a count pin.
        always_comb begin
            case (src)
                SRC_PRE: tick = pre_tick(isel, pre_cnt);
                SRC_GPT: tick = external_gp_timer_overflow_source;
                SRC_EXT: tick = (J == 0)
                    && ext_count[U] && !ext_prev[U];
                default: tick = 1'b0;
            endcase
        end

        assign ovf[t] = run && tick && tmr[t] == TMR_MAX;

        // Software writes take priority over counting.
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                tmr[t] <= '0;
                chg[t] <= 1'b0;
            end else begin
                chg[t] <= wr_tmr || (run && tick);
                if (wr_tmr) begin
                    tmr[t] <= hwdata[TW-1:0];
                end else if (ovf[t]) begin
                    tmr[t] <= rel[t];
                end else if (run && tick) begin
                    tmr[t] <= tmr[t] + 16'h0001;
                end
            end
        end

        // Reload register.
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                rel[t] <= '0;
            end else if (wr_pend
                && wr_addr == reg_addr(U, OFF_REL + 4 * J)) begin
                rel[t] <= hwdata[TW-1:0];
            end
        end
    end

    // Thirty-two channels, sixteen per unit.
    for (genvar c = 0; c < CH_N; c++) begin : g_ch
        localparam int U = c / UNIT_CH;
        localparam int K = c % UNIT_CH;
        ccu_mode_t mode;
        logic tsel;
        logic dbl;
        logic [TW-1:0] cur;
        logic cur_chg;
        logic cur_ovf;
        logic once;
        logic done;
        logic cap;
        logic tog;
        logic partner;

        assign mode = ccu_mode_t'(ctl[c][2:0]);
        assign tsel = ctl[c][CTL_TSEL];
        assign dbl = ctl[c][CTL_DBL] && (K < UNIT_CH / 2);
        assign cur = tsel ? tmr[U * 2 + 1] : tmr[U * 2];
        assign cur_chg = tsel ? chg[U * 2 + 1] : chg[U * 2];
        assign cur_ovf = tsel ? ovf[U * 2 + 1] : ovf[U * 2];
        assign once = mode == MODE_CMP2 || mode == MODE_CMP3;

        // Matching only on a fresh timer value keeps a slow timer from
        // firing the same match on every clock.
        assign hit[c] = mode[2] && cur_chg && cur == val[c]
            && !(once && done);

        assign cap = ((mode == MODE_CAP_RISE || mode == MODE_CAP_BOTH)
            && cc_pin_in[c] && !pin_prev[c])
            || ((mode == MODE_CAP_FALL || mode == MODE_CAP_BOTH)
            && !cc_pin_in[c] && pin_prev[c]);

        assign ev[c] = cap || hit[c];

        if (K < UNIT_CH / 2) begin : g_pair
            assign partner = hit[c + UNIT_CH / 2];
        end else begin : g_nopair
            assign partner = 1'b0;
        end

        assign tog = (mode == MODE_CMP1 && hit[c])
            || (dbl && (hit[c] || partner));

        // Channel control word.
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                ctl[c] <= CTL_RST;
            end else if (wr_pend
                && wr_addr == reg_addr(U, OFF_CTL + 4 * K)) begin
                ctl[c] <= hwdata[CTL_W-1:0];
            end
        end

        // A capture beats a software write in the same cycle.
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                val[c] <= '0;
                pin_prev[c] <= 1'b0;
            end else begin
                pin_prev[c] <= cc_pin_in[c];
                if (cap) begin
                    val[c] <= cur;
                end else if (wr_pend
                    && wr_addr == reg_addr(U, OFF_VAL + 4 * K)) begin
                    val[c] <= hwdata[TW-1:0];
                end
            end
        end

        // One-match-per-period latch, rearmed by the timer overflow.
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                done <= 1'b0;
            end else if (cur_ovf) begin
                done <= 1'b0;
            end else if (hit[c] && once) begin
                done <= 1'b1;
            end
        end

        // Pin driver; it drives in compare modes 1 and 3 and when double mode is set on channels 0 to 7 of a unit.
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                cc_pin_out[c] <= 1'b0;
                cc_pin_oe[c] <= 1'b0;
            end else begin
                cc_pin_oe[c] <= mode == MODE_CMP1 || mode == MODE_CMP3
                    || dbl;
                if (mode == MODE_CMP3 && cur_ovf) begin
                    cc_pin_out[c] <= 1'b0;
                end else if (mode == MODE_CMP3 && hit[c]) begin
                    cc_pin_out[c] <= 1'b1;
                end else if (tog) begin
                    cc_pin_out[c] <= !cc_pin_out[c];
                end
            end
        end
    end

    // Sticky event flags, write one to clear; a new event wins.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stat <= '0;
        end else if (wr_pend && wr_addr == ADDR_STAT) begin
            stat <= (stat & ~hwdata) | ev;
        end else begin
            stat <= stat | ev;
        end
    end

    // Interrupt mask and the single level output.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mask <= '0;
            irq <= 1'b0;
        end else begin
            if (wr_pend && wr_addr == ADDR_MASK) begin
                mask <= hwdata;
            end
            irq <= |(stat & mask);
        end
    end
endmodule

// ### verification/ccu_pin_model.sv
// Far-side model: channel pin levels, count pin and overflow pulse source.
`timescale 1ns/1ns
module ccu_pin_model (
    input wire logic ref_clk,
    output logic ovf,
    output logic [1:0] ext_cnt,
    output logic [31:0] lvl
);
    // All lines start quiet so that no edge is seen on the first clock.
    initial begin
        ovf = 1'b0;
        ext_cnt = 2'h0;
        lvl = 32'h0;
    end

    // Single-clock overflow pulses with a quiet clock between them.
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            ovf <= 1'b1;
            @(posedge ref_clk);
            ovf <= 1'b0;
        end
    endtask

    // Rising edges on the unit A count pin, one clock high, one low.
    task automatic count(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            ext_cnt[0] <= 1'b1;
            @(posedge ref_clk);
            ext_cnt[0] <= 1'b0;
        end
    endtask

    // Moves one channel pin just after a clock edge.
    task automatic pin(input int c, input logic v);
        @(posedge ref_clk);
        lvl[c] <= v;
    endtask
endmodule

// ### verification/ccu_monitor.sv
// Bus, pin and interrupt assertions for the capture/compare block.
`timescale 1ns/1ns
module ccu_monitor (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [31:0] cc_pin_out,
    input wire logic [31:0] cc_pin_oe,
    input wire logic irq
);
    logic take;
    logic wr_dp;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // A transfer is taken at any edge that sees an active selected request.
    assign take = hsel && htrans[1] && hready;

    // Marks a write data phase; only writes may reconfigure or clear.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_dp <= 1'b0;
        end else begin
            wr_dp <= take && hwrite;
        end
    end

    sequence rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    hresp_okay_a: assert property (!hresp)
        else $error("response not OKAY");
    read_wait_a: assert property (take && !hwrite |=> rd_wait)
        else $error("read wait state wrong");
    write_nowait_a: assert property (take && hwrite |=> hreadyout)
        else $error("write was stalled");
    wait_cause_a: assert property ($fell(hreadyout) |-> $past(take && !hwrite))
        else $error("wait state without a read");
    rdata_hold_a: assert property
        ($changed(hrdata) |-> $rose(hreadyout) || $fell(hreadyout))
        else $error("read data moved outside a read");
    pin_drive_a: assert property
        (((cc_pin_out ^ $past(cc_pin_out)) & ~cc_pin_oe) == 32'h0)
        else $error("undriven pin changed level");
    oe_cause_a: assert property
        ($changed(cc_pin_oe) |-> $past(wr_dp) || $past(wr_dp, 2))
        else $error("pin enable changed without a write");
    irq_clear_a: assert property
        ($fell(irq) |-> $past(wr_dp) || $past(wr_dp, 2))
        else $error("interrupt dropped without a write");
    reset_quiet_a: assert property
        ($rose(arst_n) |-> !irq && cc_pin_oe == 32'h0)
        else $error("outputs active after reset");
endmodule

bind ccu_top ccu_monitor i_ccu_monitor (.ref_clk, .arst_n, .hsel, .htrans,
    .hwrite, .hready, .hreadyout, .hresp, .hrdata, .cc_pin_out, .cc_pin_oe,
    .irq);

// ### verification/tb_top.sv
// Self-checking bench for the capture/compare block.
`timescale 1ns/1ns
module tb_top;
    import ccu_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, irq, ovf, p;
    logic [1:0] ext_cnt;
    logic [31:0] hrdata, pin_out, pin_oe, pin_in, lvl, rv;
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;

    // A driven pin shows the block's level, otherwise the model's.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & lvl);

    ccu_top i_ccu_top (.ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata),
        .external_gp_timer_overflow_source(ovf), .ext_count(ext_cnt),
        .cc_pin_in(pin_in), .cc_pin_out(pin_out), .cc_pin_oe(pin_oe),
        .irq(irq));
    ccu_pin_model i_ccu_pin_model (.ref_clk(ref_clk), .ovf(ovf),
        .ext_cnt(ext_cnt), .lvl(lvl));

    always #4 ref_clk = ~ref_clk;

    // Cuts a hang short; the whole run needs far fewer cycles.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic conclude;
        $display("Counts: %0d mismatches in %0d checks", miscompares,
            cmp_count);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    // One single AHB transfer; read data is taken at the closing edge.
    task automatic bus(input logic [31:0] a, d, input logic w);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, d);
        bus(a, d, 1'b1);
    endtask

    task automatic rdc(input logic [31:0] a, e, input string n);
        bus(a, 32'h0, 1'b0);
        chk(n, e, rv);
    endtask

    // Overflow pulses, then status and channel 0 pin are judged.
    task automatic step(input int n, input logic [31:0] st, input logic pe);
        i_ccu_pin_model.pulse(n);
        repeat (4) @(posedge ref_clk);
        rdc(32'h200, st, "stat");
        chk("pin", {31'h0, pe}, {31'h0, pin_out[0]});
        wr(32'h200, 32'hFFFFFFFF);
    endtask

    // Reset values, and an unmapped place that keeps nothing.
    task automatic t_reset;
        rdc(32'h80, 32'h0, "ctl");
        rdc(32'h200, 32'h0, "stat");
        wr(32'h300, 32'hFFFFFFFF);
        rdc(32'h300, 32'h0, "unmapped");
    endtask

    // Every prescaler code: five periods should give five or six ticks.
    task automatic t_presc;
        for (int k = 0; k < 8; k++) begin
            wr(32'h0, 32'h0);
            wr(32'h10, 32'h20 | k);
            repeat ((8 << k) * 5) @(posedge ref_clk);
            bus(32'h0, 32'h0, 1'b0);
            wr(32'h10, 32'h0);
            chk("prescale", 32'h1, {31'h0, rv[15:0] == 16'h5 ||
                rv[15:0] == 16'h6});
        end
    endtask

    // Overflow source with reload, then the count pin.
    task automatic t_src;
        wr(32'h8, 32'h1234);
        wr(32'h0, 32'hFFFE);
        wr(32'h10, 32'h28);
        i_ccu_pin_model.pulse(3);
        rdc(32'h0, 32'h1235, "reload");
        wr(32'h10, 32'h30);
        i_ccu_pin_model.count(4);
        rdc(32'h0, 32'h1239, "count pin");
        wr(32'h10, 32'h0);
    endtask

    // Unit B channel 1 on timer 1, every capture edge choice.
    task automatic t_capture;
        wr(32'h204, 32'hFFFFFFFF);
        for (int m = 1; m < 4; m++) begin
            wr(32'h104, 32'h100 * m);
            wr(32'h184, 32'h8 | m);
            i_ccu_pin_model.pin(17, 1'b1);
            repeat (4) @(posedge ref_clk);
            chk("irq", {31'h0, m != 2}, {31'h0, irq});
            rdc(32'h200, (m != 2) ? 32'h20000 : 32'h0, "rise");
            wr(32'h200, 32'hFFFFFFFF);
            i_ccu_pin_model.pin(17, 1'b0);
            repeat (4) @(posedge ref_clk);
            rdc(32'h200, (m != 1) ? 32'h20000 : 32'h0, "fall");
            rdc(32'h144, 32'h100 * m, "capture");
            wr(32'h200, 32'hFFFFFFFF);
        end
        i_ccu_pin_model.pin(17, 1'b1);
        repeat (4) @(posedge ref_clk);
        chk("irq set", 32'h1, {31'h0, irq});
        wr(32'h204, 32'h0);
        // The level output follows the mask one clock after the write.
        repeat (2) @(posedge ref_clk);
        chk("masked irq", 32'h0, {31'h0, irq});
        wr(32'h204, 32'hFFFFFFFF);
        wr(32'h200, 32'hFFFFFFFF);
    endtask

    // Unit A channel 0 in each compare mode, with two matches in one timer period.
    task automatic t_compare;
        p = 1'b0;
        wr(32'h8, 32'hFFF8);
        wr(32'h40, 32'hFFFA);
        for (int m = 4; m < 8; m++) begin
            wr(32'h80, m);
            wr(32'h0, 32'hFFFF);
            wr(32'h10, 32'h28);
            p = (m == 5) ? ~p : (m == 7) ? 1'b1 : p;
            step(3, 32'h1, p);
            chk("oe", {31'h0, m == 5 || m == 7}, {31'h0, pin_oe[0]});
            wr(32'h0, 32'hFFF8);
            p = (m == 5) ? ~p : p;
            step(2, {31'h0, m < 6}, p);
            p = (m == 7) ? 1'b0 : p;
            step(6, 32'h0, p);
        end
    endtask

    // Channels 0 and 8 share channel 0's pin.
    task automatic t_double;
        wr(32'h80, 32'h14);
        wr(32'hA0, 32'h4);
        wr(32'h60, 32'hFFFB);
        wr(32'h0, 32'hFFF8);
        step(2, 32'h1, 1'b1);
        step(1, 32'h100, 1'b0);
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_presc();
        t_src();
        t_capture();
        t_compare();
        t_double();
        conclude();
    end
endmodule
